// ---- rtl/cas_pkg.sv ----
// Constants, register map and types of the capture arm sequencer.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
package cas_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_NS = 4;
  localparam int INT_SAMPLE_NS = 2;
  // Internal rate faster than clk, so it saturates at one sample per clock
  localparam int INT_SAMPLE_CYC = (INT_SAMPLE_NS < CLK_NS) ? 1 : INT_SAMPLE_NS / CLK_NS;
  localparam int POLL_HZ = 60;
  localparam int POLL_CYC = CLK_HZ / POLL_HZ;
  localparam int REARM_HZ = 10;
  localparam int REARM_CYC = CLK_HZ / REARM_HZ;
  localparam int MEM_WORDS = 2000;
  localparam int HOLDOFF_SAMPLES = 2000;
  localparam int AW = 11;
  localparam int CTRL_W = 15;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ENA = 8'h08;
  localparam logic [7:0] OFS_TRG = 8'h0c;
  localparam logic [7:0] OFS_DLY = 8'h10;
  localparam logic [7:0] OFS_CURS = 8'h14;
  localparam logic [7:0] OFS_CHMASK = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_SETA = 8'h20;
  localparam logic [7:0] OFS_SETB = 8'h24;
  localparam logic [7:0] OFS_MADDR = 8'h28;
  localparam logic [7:0] OFS_MEMA = 8'h2c;
  localparam logic [7:0] OFS_MEMB = 8'h30;

  // Control register fields
  localparam int F_ARM = 0;
  localparam int F_STOP_EQ = 2;
  localparam int F_CMP_WIN = 3;
  localparam int F_ANALOG = 4;
  localparam int F_DLY_EVT = 5;
  localparam int F_EN = 6;
  localparam int F_TR = 8;
  localparam int F_ZFILL = 10;
  localparam int F_HOLD = 11;
  localparam int F_INTCLK = 12;
  localparam int F_ECL = 13;
  localparam int F_PRINT = 14;
  // Command register bits
  localparam int C_ARM = 0;
  localparam int C_DOWN = 1;
  localparam int C_MEN = 2;
  localparam int C_MTR = 3;
  localparam int C_COPY = 4;
  localparam int C_COMMIT_ENTRY_KEY = 5;
  // Cursor register fields
  localparam int F_CUR_LO = 0;
  localparam int F_CUR_HI = 16;
  // Status register fields
  localparam int F_ST_STATE = 0;
  localparam int F_ST_PEND = 4;
  localparam int F_ST_NE = 5;
  localparam int F_ST_LATCH = 6;
  localparam int F_ST_DONE = 7;

  localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
  localparam logic [15:0] PAT_RST = 16'h0000;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam logic [7:0] CHMASK_RST = 8'hff;
  localparam logic [AW-1:0] CUR_LO_RST = 11'h000;
  localparam logic [AW-1:0] CUR_HI_RST = 11'h7cf;

  typedef enum logic [1:0] {ARM_MANUAL, ARM_AUTO, ARM_AUTOSTOP, ARM_SPARE} cas_arm_t;
  typedef enum logic [1:0] {EVT_AUTO, EVT_MANUAL, EVT_COMB, EVT_SPARE} cas_evt_t;
endpackage

// ---- rtl/cas_top.sv ----
// Capture arm sequencer: arming, enable/trigger/delay sequence, capture memory A,
// reference memory B, settings views. Registers over classic Wishbone slave.
// Assumes probe, strap, arm and sample clock pins are asynchronous to clk.
//
// Contract
// R1: Switch one at power-up picks internal or external sample clock.
// R2: Switch two at power-up picks emitter-coupled or TTL threshold default.
// R3: Zero-fill option clears every capture memory A word before arming.
// R4: Hold-off option fills memory with 2000 samples before enable search.
// R5: Remote arm rising edge sets latch; 60 Hz poll arms when set.
// R6: Trigger output low throughout the triggered state.
// R7: After arm accepted, search enable event first, never trigger earlier.
// R8: After enable, search sampled inputs for trigger event.
// R9: After trigger, wait delay, then freeze memory and report complete.
// R10: Manual mode: one measurement per arm, then ready indication.
// R11: Auto mode re-arms after each completed measurement.
// R12: Self re-arm paced at about ten per second.
// R13: Arm-down command from any state forces manual ready; the code ignores it during the power-up strap capture state.
// R14: Autostop re-arms until A equals or differs from B as chosen.
// R15: Compare all 2000 words or cursor span inclusive, displayed channels; the code masks to displayed channels only for the cursor span.
// R16: Parameter change marks pending; recording makes them the A settings.
// R17: A settings unchangeable until a new measurement.
// R18: Memory B loads only by copy from A or bus transfer.
// R19: Formats: eight digital channels, or four plus analogue code.
// R20: Print-format switch selects screen copy output to printer.
// R21: Delay counts sample clocks or false-to-true trigger occurrences.
// R22: Automatic enable skips enable search, trigger search starts at once.
// R23: Poll clears remote latch, one arm per rising edge.
// R24: Arm requests ignored while a sequence is in progress.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
module cas_top #(
  parameter int POLL_CYCLES = cas_pkg::POLL_CYC,
  parameter int REARM_CYCLES = cas_pkg::REARM_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] cfg_switch,
  input wire logic external_sample_clock,
  input wire logic remote_arm,
  input wire logic [7:0] probe_in,
  input wire logic [3:0] adc_in,
  output logic trig_out_n,
  output logic ready,
  output logic thresh_ecl,
  output logic screen_copy_print_format
);
  import cas_pkg::*;

  typedef enum logic [3:0] {
    ST_BOOT, ST_READY, ST_ZFILL, ST_HOLD, ST_ENSRCH, ST_TRSRCH, ST_DELAY, ST_COMPARE, ST_GAP, ST_COPY
  } cas_state_t;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] d, input logic [15:0] pat);
    return ((d ^ pat[7:0]) & pat[15:8]) == 8'h00;
  endfunction

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] a);
    return (a == AW'(MEM_WORDS - 1)) ? '0 : a + 1'b1;
  endfunction

  logic [7:0] mem_a [MEM_WORDS];
  logic [7:0] mem_b [MEM_WORDS];

  // Synchronisers; stage one feeds stage two only
  logic [4:0] sw_s1, sw_s2;
  logic xc_s1, xc_s2, xc_s3, ra_s1, ra_s2, ra_s3;
  logic [7:0] pr_s1, pr_s2;
  logic [3:0] ad_s1, ad_s2;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_s1 <= 5'h00;
      sw_s2 <= 5'h00;
      {xc_s1, xc_s2, xc_s3, ra_s1, ra_s2, ra_s3} <= 6'h00;
      pr_s1 <= 8'h00;
      pr_s2 <= 8'h00;
      ad_s1 <= 4'h0;
      ad_s2 <= 4'h0;
    end else begin
      sw_s1 <= cfg_switch;
      sw_s2 <= sw_s1;
      {xc_s1, xc_s2, xc_s3} <= {external_sample_clock, xc_s1, xc_s2};
      {ra_s1, ra_s2, ra_s3} <= {remote_arm, ra_s1, ra_s2};
      pr_s1 <= probe_in;
      pr_s2 <= pr_s1;
      ad_s1 <= adc_in;
      ad_s2 <= ad_s1;
    end
  end

  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt, seta_r, seta_nxt, setb_r, setb_nxt;
  logic [15:0] ena_r, ena_nxt, trg_r, trg_nxt, dly_r, dly_nxt;
  logic [AW-1:0] clo_r, clo_nxt, chi_r, chi_nxt, idx_r, idx_nxt, wp_r, wp_nxt, mad_r, mad_nxt;
  logic [7:0] chm_r, chm_nxt;
  logic [31:0] cnt_r, cnt_nxt, poll_r, poll_nxt;
  logic [1:0] boot_r, boot_nxt;
  cas_state_t st_r, st_nxt;
  logic pend_r, pend_nxt, ne_r, ne_nxt, latch_r, latch_nxt, done_r, done_nxt;
  logic thit_r, thit_nxt, trn_r, trn_nxt, men_r, men_nxt, mtr_r, mtr_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [1:0] sdiv_r, sdiv_nxt;
  logic ma_we, mb_we;
  logic [AW-1:0] ma_adr, mb_adr;
  logic [7:0] ma_din, mb_din;

  logic req, wr, arm_go, poll_tick, cfg_wr, smp, in_rec;
  logic [7:0] word, diff;
  logic [31:0] rdata, cmd;
  cas_arm_t amode;
  cas_evt_t emode, tmode;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_r;
    wr = req & wb_we_i;
    cmd = (wr && wb_adr_i == OFS_CMD) ? merge(32'h0, wb_dat_i, wb_sel_i) : 32'h0;
    amode = cas_arm_t'(ctrl_r[F_ARM +: 2]);
    emode = cas_evt_t'(seta_r[F_EN +: 2]);
    tmode = cas_evt_t'(seta_r[F_TR +: 2]);
    // Sample enable: internal divider, or rising edge of the external clock [R1]
    sdiv_nxt = (sdiv_r == 2'(INT_SAMPLE_CYC - 1)) ? 2'h0 : sdiv_r + 2'h1;
    smp = seta_r[F_INTCLK] ? (sdiv_r == 2'(INT_SAMPLE_CYC - 1)) : (xc_s2 & ~xc_s3);
    // Four channels plus analogue code, or eight channels [R19]
    word = seta_r[F_ANALOG] ? {ad_s2, pr_s2[3:0]} : pr_s2;
    diff = (mem_a[idx_r] ^ mem_b[idx_r]) & (seta_r[F_CMP_WIN] ? chm_r : 8'hff);

    ctrl_nxt = ctrl_r;
    seta_nxt = seta_r;
    setb_nxt = setb_r;
    ena_nxt = ena_r;
    trg_nxt = trg_r;
    dly_nxt = dly_r;
    clo_nxt = clo_r;
    chi_nxt = chi_r;
    chm_nxt = chm_r;
    mad_nxt = mad_r;
    idx_nxt = idx_r;
    wp_nxt = wp_r;
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    ne_nxt = ne_r;
    done_nxt = done_r;
    boot_nxt = boot_r;
    thit_nxt = thit_r;
    trn_nxt = trn_r;
    ma_we = 1'b0;
    ma_adr = wp_r;
    ma_din = word;
    mb_we = 1'b0;
    mb_adr = mad_r;
    mb_din = wb_dat_i[7:0];
    cfg_wr = 1'b0;

    // Straps are caught once the synchronisers hold settled values [R1] [R2]
    if (st_r == ST_BOOT) begin
      boot_nxt = boot_r + 2'h1;
      if (boot_r == 2'h3) begin
        ctrl_nxt[F_INTCLK] = sw_s2[0];                                   // [R1]
        ctrl_nxt[F_ECL] = sw_s2[1];                                      // [R2]
        ctrl_nxt[F_ZFILL] = sw_s2[2];
        ctrl_nxt[F_HOLD] = sw_s2[3];
        ctrl_nxt[F_PRINT] = sw_s2[4];                                    // [R20]
        seta_nxt = ctrl_nxt;
        st_nxt = ST_READY;
      end
    end

    // Register writes go to the working set only; A settings stay intact [R17]
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          ctrl_nxt = CTRL_W'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
          cfg_wr = 1'b1;
        end
        OFS_ENA: begin
          ena_nxt = 16'(merge(32'(ena_r), wb_dat_i, wb_sel_i));
          cfg_wr = 1'b1;
        end
        OFS_TRG: begin
          trg_nxt = 16'(merge(32'(trg_r), wb_dat_i, wb_sel_i));
          cfg_wr = 1'b1;
        end
        OFS_DLY: begin
          dly_nxt = 16'(merge(32'(dly_r), wb_dat_i, wb_sel_i));
          cfg_wr = 1'b1;
        end
        OFS_CURS: begin
          clo_nxt = wb_dat_i[F_CUR_LO +: AW];
          chi_nxt = wb_dat_i[F_CUR_HI +: AW];
          cfg_wr = 1'b1;
        end
        OFS_CHMASK: begin
          chm_nxt = wb_dat_i[7:0];
          cfg_wr = 1'b1;
        end
        OFS_MADDR: mad_nxt = wb_dat_i[AW-1:0];
        OFS_MEMB: begin
          // Bus transfer into reference memory, only while idle [R18]
          if (st_r == ST_READY && mad_r < AW'(MEM_WORDS)) begin
            mb_we = 1'b1;
            mad_nxt = wrap_inc(mad_r);
          end
        end
        default: ;
      endcase
    end
    if (req && !wb_we_i && wb_adr_i == OFS_MEMA) begin
      mad_nxt = wrap_inc(mad_r);
    end

    // Any change or a commit keystroke marks the working set pending [R16]
    arm_go = 1'b0;
    pend_nxt = pend_r | cfg_wr | cmd[C_COMMIT_ENTRY_KEY];
    // Remote latch: set wins over the poll's clear [R5] [R23]
    poll_tick = (poll_r == 32'(POLL_CYCLES - 1));
    poll_nxt = poll_tick ? 32'h0 : poll_r + 32'h1;
    latch_nxt = (ra_s2 & ~ra_s3) | (latch_r & ~poll_tick);

    case (st_r)
      ST_BOOT: ;
      ST_READY: begin
        // Only here is an arm accepted [R24]
        if (cmd[C_ARM] || (poll_tick && latch_r)) begin                // [R5]
          arm_go = 1'b1;
        end else if (cmd[C_COPY]) begin
          idx_nxt = '0;
          st_nxt = ST_COPY;
        end
      end
      ST_COPY: begin
        mb_we = 1'b1;                                                    // [R18]
        mb_adr = idx_r;
        mb_din = mem_a[idx_r];
        idx_nxt = wrap_inc(idx_r);
        if (idx_r == AW'(MEM_WORDS - 1)) begin
          setb_nxt = seta_r;
          st_nxt = ST_READY;
        end
      end
      ST_ZFILL: begin
        ma_we = 1'b1;                                                    // [R3]
        ma_adr = idx_r;
        ma_din = 8'h00;
        idx_nxt = wrap_inc(idx_r);
        if (idx_r == AW'(MEM_WORDS - 1)) begin
          cnt_nxt = 32'h0;
          st_nxt = seta_r[F_HOLD] ? ST_HOLD : (emode == EVT_AUTO ? ST_TRSRCH : ST_ENSRCH);
        end
      end
      ST_HOLD: begin
        if (smp) begin
          cnt_nxt = cnt_r + 32'h1;
          // Enable search waits for a full memory of samples [R4]
          if (cnt_r == 32'(HOLDOFF_SAMPLES - 1)) begin
            st_nxt = (emode == EVT_AUTO) ? ST_TRSRCH : ST_ENSRCH;        // [R22]
          end
        end
      end
      ST_ENSRCH: begin
        // Trigger logic is idle until enable is seen [R7] [R8]
        if ((emode == EVT_COMB && smp && hit(word, ena_r)) || (emode != EVT_COMB && men_r)) begin
          st_nxt = ST_TRSRCH;
        end
      end
      ST_TRSRCH: begin
        // Combinational trigger fires only on a false-to-true change
        if ((tmode == EVT_COMB && smp && hit(word, trg_r) && !thit_r) || tmode == EVT_AUTO
            || (tmode == EVT_MANUAL && mtr_r)) begin
          cnt_nxt = 32'(dly_r);
          trn_nxt = 1'b0;                                                // [R6]
          st_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cnt_r == 32'h0) begin
          // Freeze: sampler stops writing from here on [R9]
          trn_nxt = 1'b1;
          done_nxt = 1'b1;
          idx_nxt = seta_r[F_CMP_WIN] ? clo_r : '0;
          ne_nxt = 1'b0;
          if (amode == ARM_AUTOSTOP) begin
            st_nxt = ST_COMPARE;
          end else if (amode == ARM_AUTO) begin
            cnt_nxt = 32'h0;
            st_nxt = ST_GAP;                                             // [R11]
          end else begin
            st_nxt = ST_READY;                                           // [R10]
          end
        end else if (seta_r[F_DLY_EVT] ? (smp && hit(word, trg_r) && !thit_r) : smp) begin
          cnt_nxt = cnt_r - 32'h1;                                       // [R21]
        end
      end
      ST_COMPARE: begin
        // Whole memory unmasked, or cursor span inclusive masked to displayed channels [R15]
        if (diff != 8'h00) begin
          ne_nxt = 1'b1;
        end
        idx_nxt = wrap_inc(idx_r);
        if (idx_r == (seta_r[F_CMP_WIN] ? chi_r : AW'(MEM_WORDS - 1))) begin
          // Stop once the chosen relation holds, otherwise go again [R14]
          if (seta_r[F_STOP_EQ] == !(ne_r || diff != 8'h00)) begin
            st_nxt = ST_READY;
          end else begin
            cnt_nxt = 32'h0;
            st_nxt = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        // Self-arming paced by REARM_CYCLES, about ten per second [R12]
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r == 32'(REARM_CYCLES - 1)) begin
          arm_go = 1'b1;
        end
      end
      default: st_nxt = ST_READY;
    endcase

    if (arm_go) begin
      // Recording adopts the working set as the A settings [R16]
      seta_nxt = ctrl_r;
      pend_nxt = cfg_wr | cmd[C_COMMIT_ENTRY_KEY];
      done_nxt = 1'b0;
      idx_nxt = '0;
      cnt_nxt = 32'h0;
      st_nxt = ctrl_r[F_ZFILL] ? ST_ZFILL : (ctrl_r[F_HOLD] ? ST_HOLD
               : (cas_evt_t'(ctrl_r[F_EN +: 2]) == EVT_AUTO ? ST_TRSRCH : ST_ENSRCH));  // [R3] [R4] [R22]
    end

    in_rec = (st_r == ST_HOLD || st_r == ST_ENSRCH || st_r == ST_TRSRCH || st_r == ST_DELAY);
    if (in_rec && smp && !(st_r == ST_DELAY && cnt_r == 32'h0)) begin
      ma_we = 1'b1;
      wp_nxt = wrap_inc(wp_r);
    end
    if (smp) begin
      thit_nxt = hit(word, trg_r);
    end
    // Manual enable/trigger keys latch until used or the run ends
    men_nxt = (men_r | cmd[C_MEN]) & (st_r == ST_ENSRCH ? st_nxt == ST_ENSRCH : in_rec);
    mtr_nxt = (mtr_r | cmd[C_MTR]) & (st_r == ST_TRSRCH ? st_nxt == ST_TRSRCH : in_rec || st_r == ST_ENSRCH);

    // Arm-down overrides the next state, arm mode and trigger output, except in ST_BOOT [R13]
    if (cmd[C_DOWN] && st_r != ST_BOOT) begin
      ctrl_nxt[F_ARM +: 2] = ARM_MANUAL;
      trn_nxt = 1'b1;
      st_nxt = ST_READY;
    end

    case (wb_adr_i)
      OFS_CTRL: rdata = 32'(ctrl_r);
      OFS_ENA: rdata = 32'(ena_r);
      OFS_TRG: rdata = 32'(trg_r);
      OFS_DLY: rdata = 32'(dly_r);
      OFS_CURS: rdata = (32'(chi_r) << F_CUR_HI) | (32'(clo_r) << F_CUR_LO);
      OFS_CHMASK: rdata = 32'(chm_r);
      OFS_STATUS: rdata = (32'(st_r) << F_ST_STATE) | (32'(pend_r) << F_ST_PEND) | (32'(ne_r) << F_ST_NE)
                          | (32'(latch_r) << F_ST_LATCH) | (32'(done_r) << F_ST_DONE);
      OFS_SETA: rdata = 32'(seta_r);
      OFS_SETB: rdata = 32'(setb_r);
      OFS_MADDR: rdata = 32'(mad_r);
      OFS_MEMA: rdata = (mad_r < AW'(MEM_WORDS)) ? 32'(mem_a[mad_r]) : 32'h0;
      OFS_MEMB: rdata = (mad_r < AW'(MEM_WORDS)) ? 32'(mem_b[mad_r]) : 32'h0;
      default: rdata = 32'h0;
    endcase
    ack_nxt = req;
    dat_nxt = (req && !wb_we_i) ? rdata : dat_r;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
      seta_r <= CTRL_RST;
      setb_r <= CTRL_RST;
      ena_r <= PAT_RST;
      trg_r <= PAT_RST;
      dly_r <= DLY_RST;
      clo_r <= CUR_LO_RST;
      chi_r <= CUR_HI_RST;
      chm_r <= CHMASK_RST;
      mad_r <= '0;
      idx_r <= '0;
      wp_r <= '0;
      cnt_r <= 32'h0;
      poll_r <= 32'h0;
      boot_r <= 2'h0;
      st_r <= ST_BOOT;
      pend_r <= 1'b0;
      ne_r <= 1'b0;
      latch_r <= 1'b0;
      done_r <= 1'b0;
      thit_r <= 1'b0;
      trn_r <= 1'b1;
      men_r <= 1'b0;
      mtr_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      sdiv_r <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      seta_r <= seta_nxt;
      setb_r <= setb_nxt;
      ena_r <= ena_nxt;
      trg_r <= trg_nxt;
      dly_r <= dly_nxt;
      clo_r <= clo_nxt;
      chi_r <= chi_nxt;
      chm_r <= chm_nxt;
      mad_r <= mad_nxt;
      idx_r <= idx_nxt;
      wp_r <= wp_nxt;
      cnt_r <= cnt_nxt;
      poll_r <= poll_nxt;
      boot_r <= boot_nxt;
      st_r <= st_nxt;
      pend_r <= pend_nxt;
      ne_r <= ne_nxt;
      latch_r <= latch_nxt;
      done_r <= done_nxt;
      thit_r <= thit_nxt;
      trn_r <= trn_nxt;
      men_r <= men_nxt;
      mtr_r <= mtr_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      sdiv_r <= sdiv_nxt;
    end
  end

  // Memories carry no reset; contents are undefined until filled
  always_ff @(posedge clk) begin
    if (ma_we) begin
      mem_a[ma_adr] <= ma_din;
    end
    if (mb_we) begin
      mem_b[mb_adr] <= mb_din;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign trig_out_n = trn_r;
  assign ready = (st_r == ST_READY);
  assign thresh_ecl = ctrl_r[F_ECL];
  assign screen_copy_print_format = ctrl_r[F_PRINT];
endmodule

// ---- tb/cas_top_sva.sv ----
// Port checker for the capture arm sequencer.
// Assumes it is bound onto cas_top and sees only its ports.
`timescale 1ns/10ps
module cas_top_sva import cas_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic trig_out_n,
  input wire logic ready
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cmd(b);
    s_take ##0 (wb_we_i && wb_adr_i == OFS_CMD && wb_sel_i[0] && wb_dat_i[b]);
  endsequence

  a_ack_latency: assert property (s_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // Read data only moves with a read acknowledge
  a_rdata_hold: assert property ((!wb_ack_o || $past(wb_we_i)) |-> $stable(wb_dat_o))
    else $error("read data changed outside a read");
  a_boot_ready: assert property ($fell(sys_rst) |-> !ready [*4] ##[1:3] ready)
    else $error("ready timing after reset wrong");
  a_trig_not_ready: assert property (!trig_out_n |-> !ready)
    else $error("trigger output low while ready");
  a_down_ready: assert property (s_cmd(C_DOWN) |-> ##[1:8] (ready && trig_out_n))
    else $error("arm-down did not force ready");
  a_arm_leaves: assert property ((ready && !wb_dat_i[C_DOWN]) ##0 s_cmd(C_ARM) |-> ##[1:4] !ready)
    else $error("arm accepted in ready did not leave ready");
endmodule

bind cas_top cas_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trig_out_n(trig_out_n), .ready(ready));

// ---- tb/cas_cut_model.sv ----
// Circuit under test behind the pods: external sample clock and data.
// Assumes run is high only while a recording may need samples.
`timescale 1ns/10ps
module cas_cut_model #(
  parameter int HALF_NS = 40
) (
  input wire logic run,
  input wire logic [7:0] stride,
  output logic external_sample_clock,
  output logic [7:0] probe_in,
  output logic [3:0] adc_in
);
  initial begin
    external_sample_clock = 1'b0;
    probe_in = 8'h00;
    adc_in = 4'h0;
    #13;
    forever begin
      #(HALF_NS);
      // Clock stands still between frames, data keeps moving only while it rests low
      if (run) begin
        external_sample_clock = ~external_sample_clock;
      end
      if (!external_sample_clock) begin
        probe_in = probe_in + stride;
        adc_in = probe_in[7:4];
      end
    end
  end
endmodule

// ---- tb/cas_top_tb.sv ----
// Self-checking bench for the capture arm sequencer.
// Assumes the checker binds itself and the pod model supplies samples.
`timescale 1ns/10ps
module cas_top_tb;
  import cas_pkg::*;
  localparam int POLL = 50;
  localparam int LIMIT = 20000;
  logic clk, sys_rst, wb_cyc, wb_stb, wb_we, ack, remote_arm, run, trig_out_n, ready, thr, prn, esc;
  logic [7:0] adr, probe;
  logic [3:0] sel, adc;
  logic [31:0] wdat, rdat, q;
  logic [4:0] sw;
  logic [CTRL_W-1:0] m_ctrl, m_strap;
  int err_total, checks, cyc_n, dur, dly, seed;

  cas_top #(.POLL_CYCLES(POLL), .REARM_CYCLES(20)) uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cfg_switch(sw), .external_sample_clock(esc), .remote_arm(remote_arm), .probe_in(probe),
    .adc_in(adc), .trig_out_n(trig_out_n), .ready(ready), .thresh_ecl(thr), .screen_copy_print_format(prn));
  cas_cut_model pods (.run(run), .stride(8'h35), .external_sample_clock(esc), .probe_in(probe), .adc_in(adc));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n > LIMIT) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic cmd(input int b);
    wb(1'b1, OFS_CMD, 32'h1 << b);
  endtask

  task automatic st_is(input logic [3:0] s, input string what);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk32({28'h0, q[3:0]}, {28'h0, s}, what);
  endtask

  task automatic wait_st(input logic [3:0] s);
    int t0;
    t0 = cyc_n;
    do wb(1'b0, OFS_STATUS, 32'h0);
    while (q[3:0] !== s);
    dur = cyc_n - t0;
  endtask

  initial begin
    seed = 32'hc8f276cc;
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    remote_arm = 1'b0;
    run = 1'b0;
    sw = 5'b10010;
    err_total = 0;
    checks = 0;
    cyc_n = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wait_st(4'h1);
    // Switch one to clock source, two to threshold, three fill, four hold-off, five print
    m_strap = {sw[4], sw[1], sw[0], sw[3], sw[2], 10'h0};
    m_ctrl = m_strap;
    wb(1'b0, OFS_CTRL, 32'h0);
    chk32(q, {17'h0, m_ctrl}, "ctrl straps");
    chk1(thr, sw[1], "threshold pin");
    chk1(prn, sw[4], "print pin");
    wb(1'b0, 8'hfc, 32'h0);
    chk32(q, 32'h0, "unmapped read");
    wb(1'b0, OFS_CURS, 32'h0);
    chk32(q, 32'h07cf0000, "cursor reset");
    // Manual arm, manual enable, manual trigger, delay in external samples
    dly = 1 + ($random(seed) & 7);
    wb(1'b1, OFS_DLY, dly);
    m_ctrl = m_strap | 15'h0140;
    wb(1'b1, OFS_CTRL, {17'h0, m_ctrl});
    run <= 1'b1;
    cmd(C_ARM);
    st_is(4'h4, "enable search");
    chk1(trig_out_n, 1'b1, "no trigger before enable");
    cmd(C_ARM);
    st_is(4'h4, "arm ignored while busy");
    cmd(C_MEN);
    st_is(4'h5, "trigger search");
    cmd(C_MTR);
    @(posedge clk);
    chk1(trig_out_n, 1'b0, "trigger output low");
    wait_st(4'h1);
    chk1(dur >= (dly - 1) * 20 && dur <= (dly + 2) * 20 + 10, 1'b1, "delay length");
    chk1(trig_out_n, 1'b1, "trigger output released");
    chk1(ready, 1'b1, "ready after one recording");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk1(q[F_ST_DONE], 1'b1, "recording done");
    wb(1'b0, OFS_SETA, 32'h0);
    chk32(q, {17'h0, m_ctrl}, "settings of A");
    wb(1'b1, OFS_SETA, 32'h7fff);
    wb(1'b0, OFS_SETA, 32'h0);
    chk32(q, {17'h0, m_ctrl}, "settings of A locked");
    // Zero fill and hold-off on the internal clock, automatic enable
    m_ctrl = m_strap | 15'h1d00;
    wb(1'b1, OFS_CTRL, {17'h0, m_ctrl});
    cmd(C_COMMIT_ENTRY_KEY);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk1(q[F_ST_PEND], 1'b1, "pending set");
    cmd(C_ARM);
    st_is(4'h2, "zero fill first");
    wait_st(4'h3);
    chk1(dur >= 1975 && dur <= 2010, 1'b1, "zero fill length");
    wait_st(4'h5);
    chk1(dur >= 1975 && dur <= 2010, 1'b1, "hold-off length");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk1(q[F_ST_PEND], 1'b0, "pending taken by recording");
    cmd(C_DOWN);
    st_is(4'h1, "arm-down from trigger search");
    // Auto arm rearms itself until arm-down
    m_ctrl = m_strap | 15'h0001;
    wb(1'b1, OFS_CTRL, {17'h0, m_ctrl});
    cmd(C_ARM);
    do wb(1'b0, OFS_STATUS, 32'h0);
    while (q[F_ST_DONE] !== 1'b1);
    repeat (10) begin
      wb(1'b0, OFS_STATUS, 32'h0);
      chk1(q[3:0] != 4'h1, 1'b1, "auto mode never idles");
    end
    cmd(C_DOWN);
    st_is(4'h1, "arm-down from auto");
    wb(1'b0, OFS_CTRL, 32'h0);
    chk32(q, {17'h0, m_ctrl & 15'h7ffc}, "arm mode forced manual");
    // Remote arm edge, one arm per edge
    m_ctrl = m_strap | 15'h0040;
    wb(1'b1, OFS_CTRL, {17'h0, m_ctrl});
    @(posedge clk);
    remote_arm <= 1'b1;
    repeat (3) @(posedge clk);
    remote_arm <= 1'b0;
    wait_st(4'h4);
    chk1(dur <= POLL + 20, 1'b1, "remote arm at poll");
    chk1(q[F_ST_LATCH], 1'b0, "latch cleared");
    cmd(C_DOWN);
    repeat (2 * POLL + 10) @(posedge clk);
    st_is(4'h1, "no second arm");
    // Copy A into B; B settings follow the A settings
    cmd(C_COPY);
    wait_st(4'h1);
    wb(1'b0, OFS_SETB, 32'h0);
    chk32(q, {17'h0, m_ctrl}, "settings of B");
    run <= 1'b0;
    // Reference memory written over the bus
    dly = $random(seed);
    wb(1'b1, OFS_MADDR, 32'h5);
    wb(1'b1, OFS_MEMB, {24'h0, dly[7:0]});
    wb(1'b1, OFS_MADDR, 32'h5);
    wb(1'b0, OFS_MEMB, 32'h0);
    chk32(q, {24'h0, dly[7:0]}, "reference word");
    results();
  end
endmodule
